// ### serial_link_ilas_tx.sv
// Purpose: link-layer lane alignment and data phase transmitter
// Assumes: one octet per lane per clock, samples from on-chip logic
// Notes:   one sample set leaves the fifo at each frame start in the data phase
`timescale 1ns/10ps
`include "slit_cfg.svh"

module slit_fifo #(
  parameter int W = `SLIT_FIFO_W,
  parameter int D = `SLIT_FIFO_D
) (
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         reset_n_i,
  // fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } slit_fifo_st_type;
  slit_fifo_st_type q, d;
  logic push, pop;

  assign in_ready_o  = q.cnt != (AW+1)'(D);
  assign out_valid_o = q.cnt != '0;
  assign out_data_o  = q.mem[q.rp];

  always_comb begin
    d = q;
    push = in_valid_i && in_ready_o;
    pop  = out_valid_o && out_ready_i;
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp = (q.wp == AW'(D-1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == AW'(D-1)) ? '0 : q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

module serial_link_ilas_tx (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  // register port
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic [7:0]       reg_rdata_o,
  // link control
  input  wire logic        sync_n_i,
  input  wire logic        subclass_i,
  // sample stream
  input  wire logic        smp_valid_i,
  output logic             smp_ready_o,
  input  wire logic [13:0] smp_a_i,
  input  wire logic [13:0] smp_b_i,
  input  wire logic [1:0]  smp_ctrl_a_i,
  input  wire logic [1:0]  smp_ctrl_b_i,
  // lanes
  output logic [7:0]       lane0_data_o,
  output logic             lane0_k_o,
  output logic [7:0]       lane1_data_o,
  output logic             lane1_k_o
);
  import slit_pkg::*;

  slit_regs_type q, d;
  logic        l2, m2, hd, f_last, k_last, mf_last, pop, fvalid;
  logic [1:0]  fm1, fsh, bi, mode, tb, ta_v, tb_v;
  logic [6:0]  pos;
  logic [3:0]  idx;
  logic [7:0]  base, cks0, cks1, raw, oct, rv, oct0;
  logic [4:0]  lid;
  logic [22:0] sres;
  logic [31:0] fdata, snow, w;
  logic        rep;

  function automatic logic [22:0] slit_scr8(input logic [14:0] st, input logic [7:0] dat);
    logic [14:0] s;
    logic [7:0]  o;
    logic        b;
    s = st;
    o = '0;
    for (int j = 7; j >= 0; j--) begin
      b = dat[j] ^ s[14] ^ s[13];
      s = {s[13:0], b};
      o[j] = b;
    end
    return {s, o};
  endfunction

  slit_fifo #(.W(`SLIT_FIFO_W), .D(`SLIT_FIFO_D)) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (smp_valid_i),
    .in_ready_o  (smp_ready_o),
    .in_data_i   ({smp_a_i, smp_b_i, smp_ctrl_a_i, smp_ctrl_b_i}),
    .out_valid_o (fvalid),
    .out_ready_i (pop),
    .out_data_o  (fdata)
  );

  assign reg_rdata_o  = q.rdata;
  assign lane0_data_o = q.lane_d[0];
  assign lane0_k_o    = q.lane_k[0];
  assign lane1_data_o = q.lane_d[1];
  assign lane1_k_o    = q.lane_k[1];

  always_comb begin
    d = q;
    rep = 1'b0; raw = '0; oct = '0; oct0 = '0; rv = '0; idx = '0; lid = '0; bi = '0;
    sres = '0;
    d.sync1 = sync_n_i;
    d.sync2 = q.sync1;
    // derived link shape
    l2 = q.qcfg[1];
    m2 = q.qcfg[5];
    fm1 = l2 ? (m2 ? 2'h1 : 2'h0) : (m2 ? 2'h3 : 2'h1);
    hd = l2 & ~m2;
    fsh = {fm1[1], fm1[0] & ~fm1[1]};
    mode = q.lctl[`SLIT_LC_ILAS_HI:`SLIT_LC_ILAS_LO];
    pos = 7'({2'h0, q.fidx} << fsh) + {5'h00, q.fpos};
    f_last = q.fpos == fm1;
    k_last = q.fidx == q.km1;
    mf_last = f_last && k_last;
    // checksum over unpacked fields, ids added per lane
    base = q.did + 8'(q.bid) + 8'(q.scr) + 8'(l2) + 8'(fm1) + 8'(q.km1) + 8'(m2)
         + 8'(q.cs) + 8'(`SLIT_N_M1) + 8'(subclass_i) + 8'(`SLIT_NP_M1)
         + 8'(`SLIT_JESDV) + 8'(`SLIT_S_M1) + 8'(hd) + 8'(`SLIT_CF_VAL);
    cks0 = base + 8'(q.lid0);
    cks1 = base + 8'(q.lid1);
    // free-running frame and multiframe counters
    if (f_last) begin
      d.fpos = '0;
      d.fidx = k_last ? '0 : q.fidx + 1'b1;
    end else begin
      d.fpos = q.fpos + 1'b1;
    end
    // register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        `SLIT_A_TAIL: d.tail = reg_wdata_i;
        `SLIT_A_QCFG: d.qcfg = reg_wdata_i;
        `SLIT_A_LCTL: d.lctl = reg_wdata_i;
        `SLIT_A_DID:  d.did  = reg_wdata_i;
        `SLIT_A_BID:  d.bid  = reg_wdata_i[3:0];
        `SLIT_A_LID0: d.lid0 = reg_wdata_i[4:0];
        `SLIT_A_LID1: d.lid1 = reg_wdata_i[4:0];
        `SLIT_A_SCRL: d.scr  = reg_wdata_i[7];
        `SLIT_A_KPM:  d.km1  = reg_wdata_i[4:0];
        `SLIT_A_CSN:  d.cs   = reg_wdata_i[7:6];
        default: d.rdata = q.rdata;
      endcase
    end
    // register reads, fixed and derived values
    if (reg_rd_i) begin
      case (reg_addr_i)
        `SLIT_A_TAIL: rv = q.tail;
        `SLIT_A_QCFG: rv = q.qcfg;
        `SLIT_A_LCTL: rv = q.lctl;
        `SLIT_A_DID:  rv = q.did;
        `SLIT_A_BID:  rv = {4'h0, q.bid};
        `SLIT_A_LID0: rv = {3'h0, q.lid0};
        `SLIT_A_LID1: rv = {3'h0, q.lid1};
        `SLIT_A_SCRL: rv = {q.scr, 6'h00, l2};
        `SLIT_A_FPF:  rv = {6'h00, fm1};
        `SLIT_A_KPM:  rv = {3'h0, q.km1};
        `SLIT_A_MCNT: rv = {7'h00, m2};
        `SLIT_A_CSN:  rv = {q.cs, 1'b0, `SLIT_N_M1};
        `SLIT_A_NP:   rv = {3'h0, `SLIT_NP_M1};
        `SLIT_A_SPF:  rv = {3'h0, `SLIT_S_M1};
        `SLIT_A_HDCF: rv = {hd, 2'h0, `SLIT_CF_VAL};
        `SLIT_A_CKS0: rv = cks0;
        `SLIT_A_CKS1: rv = cks1;
        default:      rv = 8'h00;
      endcase
      d.rdata = rv;
    end
    // sample formatting with tail and control bits
    tb = q.lctl[`SLIT_LC_PRN] ? q.lfsr[1:0] : (q.tail[`SLIT_TAIL_EN] ? q.tail[6:5] : 2'h0);
    ta_v = tb;
    tb_v = tb;
    if (q.cs != 2'h0) begin
      ta_v[1] = fdata[3];
      tb_v[1] = fdata[1];
    end
    if (q.cs[1]) begin
      ta_v[0] = fdata[2];
      tb_v[0] = fdata[0];
    end
    snow = fvalid ? {fdata[31:18], ta_v, fdata[17:4], tb_v} : 32'h0000_0000;
    pop = (q.state == LS_DATA) && (q.fpos == 2'h0);
    if (pop) begin
      d.samp = snow;
      d.lfsr = {q.lfsr[13:0], q.lfsr[14] ^ q.lfsr[13]};
    end
    w = (q.fpos == 2'h0) ? snow : q.samp;
    // per-lane octet generation
    for (int i = 0; i < 2; i++) begin
      lid = (i == 0) ? q.lid0 : q.lid1;
      bi = l2 ? (m2 ? {i[0], q.fpos[0]} : {1'b0, i[0]}) : q.fpos;
      raw = w[31 - 8*bi -: 8];
      sres = slit_scr8(q.scr_st[i], raw);
      oct = q.scr ? sres[7:0] : raw;
      if (i == 0) begin
        oct0 = oct;
      end
      d.lane_k[i] = 1'b0;
      d.lane_d[i] = 8'h00;
      if (i == 0 || l2) begin
        case (q.state)
          LS_CGS, LS_WAIT: begin
            d.lane_k[i] = 1'b1;
            d.lane_d[i] = `SLIT_K_K;
          end
          LS_ILAS: begin
            d.lane_d[i] = {1'b0, pos};
            idx = 4'(pos - 7'h02);
            if (pos == 7'h00) begin
              d.lane_k[i] = 1'b1;
              d.lane_d[i] = `SLIT_K_R;
            end else if (mf_last) begin
              d.lane_k[i] = 1'b1;
              d.lane_d[i] = `SLIT_K_A;
            end else if (q.mf == 2'h1 && pos == 7'h01) begin
              d.lane_k[i] = 1'b1;
              d.lane_d[i] = `SLIT_K_Q;
            end else if (q.mf == 2'h1 && pos < 7'h10) begin
              case (idx)
                4'h0: d.lane_d[i] = q.did;
                4'h1: d.lane_d[i] = {4'h0, q.bid};
                4'h2: d.lane_d[i] = {3'h0, lid};
                4'h3: d.lane_d[i] = {q.scr, 6'h00, l2};
                4'h4: d.lane_d[i] = {6'h00, fm1};
                4'h5: d.lane_d[i] = {3'h0, q.km1};
                4'h6: d.lane_d[i] = {7'h00, m2};
                4'h7: d.lane_d[i] = {q.cs, 1'b0, `SLIT_N_M1};
                4'h8: d.lane_d[i] = {2'h0, subclass_i, `SLIT_NP_M1};
                4'h9: d.lane_d[i] = {`SLIT_JESDV, `SLIT_S_M1};
                4'hA: d.lane_d[i] = {hd, 2'h0, `SLIT_CF_VAL};
                4'hD: d.lane_d[i] = (i == 0) ? cks0 : cks1;
                default: d.lane_d[i] = 8'h00;
              endcase
            end
          end
          LS_DATA: begin
            if (q.scr) begin
              d.scr_st[i] = sres[22:8];
            end
            if (f_last) begin
              rep = q.scr ? (oct == (k_last ? `SLIT_K_A : `SLIT_K_F))
                          : (oct == q.prev[i]);
              d.prev[i] = oct;
            end
            d.lane_k[i] = rep;
            d.lane_d[i] = rep ? (k_last ? `SLIT_K_A : `SLIT_K_F) : oct;
          end
          default: d.lane_d[i] = 8'h00;
        endcase
      end
    end
    // link sequencing
    case (q.state)
      LS_OFF: begin
        d.state = LS_CGS;
      end
      LS_CGS: begin
        if (q.sync2) begin
          d.state = LS_WAIT;
        end
      end
      LS_WAIT: begin
        if (!q.sync2) begin
          d.state = LS_CGS;
        end else if (!subclass_i || mf_last) begin
          d.state = (mode == `SLIT_ILAS_OFF) ? LS_DATA : LS_ILAS;
          d.mf = 2'h0;
          if (!subclass_i) begin
            d.fpos = '0;
            d.fidx = '0;
          end
        end
      end
      LS_ILAS: begin
        if (!q.sync2) begin
          d.state = LS_CGS;
        end else if (mf_last) begin
          d.mf = q.mf + 1'b1;
          if (q.mf == 2'h3 && mode != `SLIT_ILAS_LOOP) begin
            d.state = LS_DATA;
          end
        end
      end
      LS_DATA: begin
        if (!q.sync2) begin
          d.state = LS_CGS;
        end
      end
      default: d.state = LS_OFF;
    endcase
    if (q.lctl[`SLIT_LC_HOLD]) begin
      d.state = LS_OFF;
      d.scr_st = '0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q      <= '0;
      q.qcfg <= `SLIT_QCFG_RST;
      q.lctl <= `SLIT_LCTL_RST;
      q.tail <= `SLIT_TAIL_RST;
      q.km1  <= `SLIT_KM1_RST;
      q.scr  <= 1'b1;
      q.lfsr <= `SLIT_PRN_SEED;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sync_gate_a: assert property ((q.state != LS_ILAS) ##1 (q.state == LS_ILAS)
    |-> $past(q.sync2)) else $error("alignment began without sync high");
  sub1_align_a: assert property ((q.state != LS_ILAS) ##1 (q.state == LS_ILAS)
    |-> (pos == 7'h00) && (q.mf == 2'h0)) else $error("alignment off boundary");
  ilas_open_a: assert property ((q.state == LS_ILAS) && (pos == 7'h00)
    |=> lane0_k_o && (lane0_data_o == 8'h1C)) else $error("multiframe not opened by R");
  ilas_close_a: assert property ((q.state == LS_ILAS) && mf_last && q.sync2
    |=> lane0_k_o && (lane0_data_o == 8'h7C)) else $error("multiframe not closed by A");
  ilas_q_a: assert property ((q.state == LS_ILAS) && (q.mf == 2'h1) && (pos == 7'h01)
    |=> lane0_k_o && (lane0_data_o == 8'h9C)) else $error("Q symbol missing");
  ilas_cks_a: assert property ((q.state == LS_ILAS) && (q.mf == 2'h1) && (pos == 7'h0F)
    |=> !lane0_k_o && (lane0_data_o == $past(cks0))) else $error("checksum octet wrong");
  ilas_len_a: assert property ((q.state == LS_ILAS) && (q.mf == 2'h3) && mf_last
    && q.sync2 && !q.lctl[0] && (mode != 2'h2) |=> (q.state == LS_DATA))
    else $error("data phase not entered after fourth multiframe");
  scr_rep_a: assert property ((q.state == LS_DATA) && q.scr && f_last && !k_last
    && (oct0 == 8'hFC) |=> lane0_k_o && (lane0_data_o == 8'hFC))
    else $error("scrambled frame end not replaced");
  mf_rep_a: assert property ((q.state == LS_DATA) && !q.scr && mf_last
    && (oct0 == q.prev[0]) |=> lane0_k_o && (lane0_data_o == 8'h7C))
    else $error("repeated multiframe end not replaced by A");
  mid_frame_a: assert property ((q.state == LS_DATA) && !f_last |=> !lane0_k_o)
    else $error("control symbol inside a frame");
endmodule

// ### slit_cfg.svh
// Purpose: constants for the lane alignment transmitter
// Assumes: byte-wide register port, octet-wide lanes
// Notes:   offsets, fields, reset values and control symbols
`ifndef SLIT_CFG_SVH
`define SLIT_CFG_SVH
`define SLIT_A_TAIL     8'h14
`define SLIT_A_QCFG     8'h5E
`define SLIT_A_LCTL     8'h5F
`define SLIT_A_DID      8'h64
`define SLIT_A_BID      8'h65
`define SLIT_A_LID0     8'h66
`define SLIT_A_LID1     8'h67
`define SLIT_A_SCRL     8'h6E
`define SLIT_A_FPF      8'h6F
`define SLIT_A_KPM      8'h70
`define SLIT_A_MCNT     8'h71
`define SLIT_A_CSN      8'h72
`define SLIT_A_NP       8'h73
`define SLIT_A_SPF      8'h74
`define SLIT_A_HDCF     8'h75
`define SLIT_A_CKS0     8'h79
`define SLIT_A_CKS1     8'h7A
`define SLIT_QCFG_RST   8'h22
`define SLIT_LCTL_RST   8'h00
`define SLIT_TAIL_RST   8'h00
`define SLIT_KM1_RST    5'h1F
`define SLIT_PRN_SEED   15'h7FFF
`define SLIT_LC_HOLD    0
`define SLIT_LC_ILAS_HI 3
`define SLIT_LC_ILAS_LO 2
`define SLIT_LC_PRN     6
`define SLIT_TAIL_EN    7
`define SLIT_ILAS_OFF   2'h1
`define SLIT_ILAS_LOOP  2'h2
`define SLIT_N_M1       5'h0D
`define SLIT_NP_M1      5'h0F
`define SLIT_S_M1       5'h00
`define SLIT_CF_VAL     5'h00
`define SLIT_JESDV      3'h1
`define SLIT_K_R        8'h1C
`define SLIT_K_A        8'h7C
`define SLIT_K_Q        8'h9C
`define SLIT_K_K        8'hBC
`define SLIT_K_F        8'hFC
`define SLIT_FIFO_W     32
`define SLIT_FIFO_D     8
`endif

// ### slit_pkg.sv
// Purpose: types of the lane alignment transmitter
// Assumes: two lanes at most
// Notes:   the whole top-level state is one packed struct
package slit_pkg;
  typedef enum logic [2:0] {LS_OFF, LS_CGS, LS_WAIT, LS_ILAS, LS_DATA} slit_state_type;
  typedef struct packed {
    slit_state_type   state;
    logic             sync1;
    logic             sync2;
    logic [7:0]       tail;
    logic [7:0]       qcfg;
    logic [7:0]       lctl;
    logic [7:0]       did;
    logic [3:0]       bid;
    logic [4:0]       lid0;
    logic [4:0]       lid1;
    logic             scr;
    logic [4:0]       km1;
    logic [1:0]       cs;
    logic [1:0]       fpos;
    logic [4:0]       fidx;
    logic [1:0]       mf;
    logic [31:0]      samp;
    logic [14:0]      lfsr;
    logic [1:0][14:0] scr_st;
    logic [1:0][7:0]  prev;
    logic [1:0][7:0]  lane_d;
    logic [1:0]       lane_k;
    logic [7:0]       rdata;
  } slit_regs_type;
endpackage

// ### slit_rx_model.sv
// Purpose: receiver stand-in that holds and then releases the sync pin
// Assumes: lane 0 carries idle K28.5 symbols during code group sync
// Notes:   cgs_len_i sets how promptly or slowly the receiver answers
`timescale 1ns/10ps

module slit_rx_model (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  // watched lane and answer delay
  input  wire logic [7:0] lane0_data_i,
  input  wire logic       lane0_k_i,
  input  wire logic [7:0] cgs_len_i,
  // sync pin, low requests sync
  output logic            sync_n_o
);
  logic [7:0] cnt_q;

  // counts unbroken idle symbols, then releases sync for good
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q    <= 8'h00;
      sync_n_o <= 1'b0;
    end else if (!sync_n_o) begin
      if (lane0_k_i && lane0_data_i == 8'hBC) begin
        cnt_q <= cnt_q + 8'h01;
      end else begin
        cnt_q <= 8'h00;
      end
      if (cnt_q >= cgs_len_i) begin
        sync_n_o <= 1'b1;
      end
    end
  end
endmodule

// ### serial_link_ilas_tx_tb.sv
// Purpose: self-checking bench for the lane alignment transmitter
// Assumes: scrambling off, two lanes, K of 12, subclass 0 then 1
// Notes:   drivers queue expected results and a watcher retires them
`timescale 1ns/10ps
`include "slit_cfg.svh"

module serial_link_ilas_tx_tb;
  logic        clk_sys_i, reset_n_i, reg_wr_i, reg_rd_i, sync_n_i, subclass_i;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, lane0_data_o, lane1_data_o;
  logic        smp_valid_i, smp_ready_o, lane0_k_o, lane1_k_o, rd_p, larm, lrun;
  logic [13:0] smp_a_i, smp_b_i;
  logic [1:0]  smp_ctrl_a_i, smp_ctrl_b_i, tl;
  logic [13:0] sa[24], sb[24];
  logic [31:0] rng, qt[4];
  logic [15:0] rv[12];
  logic [7:0]  rq[$], did, cgs_len;
  logic [18:0] lq[$];
  logic [3:0]  bid;
  logic [4:0]  lid0, lid1;
  int          fail_count, check_count, n;

  serial_link_ilas_tx dut (
    .clk_sys_i    (clk_sys_i),
    .reset_n_i    (reset_n_i),
    .reg_wr_i     (reg_wr_i),
    .reg_rd_i     (reg_rd_i),
    .reg_addr_i   (reg_addr_i),
    .reg_wdata_i  (reg_wdata_i),
    .reg_rdata_o  (reg_rdata_o),
    .sync_n_i     (sync_n_i),
    .subclass_i   (subclass_i),
    .smp_valid_i  (smp_valid_i),
    .smp_ready_o  (smp_ready_o),
    .smp_a_i      (smp_a_i),
    .smp_b_i      (smp_b_i),
    .smp_ctrl_a_i (smp_ctrl_a_i),
    .smp_ctrl_b_i (smp_ctrl_b_i),
    .lane0_data_o (lane0_data_o),
    .lane0_k_o    (lane0_k_o),
    .lane1_data_o (lane1_data_o),
    .lane1_k_o    (lane1_k_o)
  );

  slit_rx_model rx (
    .clk_sys_i    (clk_sys_i),
    .reset_n_i    (reset_n_i),
    .lane0_data_i (lane0_data_o),
    .lane0_k_i    (lane0_k_o),
    .cgs_len_i    (cgs_len),
    .sync_n_o     (sync_n_i)
  );

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic [7:0] cfg_oct(input int i, input logic [4:0] l);
    logic [7:0] t[14];
    t = '{did, {4'h0, bid}, {3'h0, l}, 8'h01, 8'h01, 8'h0B, 8'h01, 8'h0D,
          {2'h0, subclass_i, 5'h0F}, 8'h20, 8'h00, 8'h00, 8'h00,
          8'h00};
    t[13] = did + t[1] + t[2] + 8'h2B + 8'(subclass_i);
    return t[i];
  endfunction

  function automatic logic [8:0] ilas(input int m, input int p, input logic [4:0] l);
    if (p == 0) return {1'b1, `SLIT_K_R};
    if (p == 23) return {1'b1, `SLIT_K_A};
    if (m == 1 && p == 1) return {1'b1, `SLIT_K_Q};
    if (m == 1 && p < 16) return {1'b0, cfg_oct(p - 2, l)};
    return {1'b0, 8'(p)};
  endfunction

  // last octet of a frame before replacement; empty fifo sends a bare zero
  function automatic logic [7:0] last_oct(input int f, input logic ln);
    logic [13:0] s;
    s = ln ? sb[f] : sa[f];
    return (f < 8) ? {s[5:0], tl} : 8'h00;
  endfunction

  function automatic logic [8:0] data_oct(input int f, input int p, input logic ln);
    logic [13:0] s;
    logic [7:0]  o, r;
    s = ln ? sb[f] : sa[f];
    o = last_oct(f, ln);
    r = (f > 0) ? last_oct(f - 1, ln) : 8'h00;
    if (p == 0) return {1'b0, s[13:6]};
    if (o == r) return {1'b1, f % 12 == 11 ? `SLIT_K_A : `SLIT_K_F};
    return {1'b0, o};
  endfunction

  task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
    @(posedge clk_sys_i);
    #1;
    reg_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    #1;
    {reg_rd_i, reg_addr_i} = {1'b1, a};
    rq.push_back(e);
    @(posedge clk_sys_i);
    #1;
    reg_rd_i = 1'b0;
  endtask

  // fills the fifo while held, queues the lane stream, releases the link
  task automatic run_link();
    n = 0;
    smp_valid_i = 1'b1;
    for (int c = 0; c < 12; c++) begin
      {smp_a_i, smp_b_i} = {sa[n % 8], sb[n % 8]};
      if (smp_ready_o === 1'b1) n++;
      @(posedge clk_sys_i);
      #1;
    end
    smp_valid_i = 1'b0;
    check("fifo fill count", 18'(n), 18'h00008);
    for (int i = 0; i < 144; i++) begin
      if (i < 96) lq.push_back({1'b0, ilas(i / 24, i % 24, lid1), ilas(i / 24, i % 24, lid0)});
      else lq.push_back({1'b0, data_oct((i - 96) / 2, i % 2, 1'b1),
                         data_oct((i - 96) / 2, i % 2, 1'b0)});
    end
    larm = 1'b1;
    wr(`SLIT_A_LCTL, 8'h00);
    for (int c = 0; c < 3000 && !(lrun && lq.size() == 0); c++) @(posedge clk_sys_i);
    check("lane stream left", 18'(lq.size()), 18'h00000);
    larm = 1'b0;
  endtask

  // watcher: retires queued notes as results show up
  always @(posedge clk_sys_i) begin
    if (rd_p) begin
      check("register read", {10'h000, reg_rdata_o}, {10'h000, rq.pop_front()});
    end
    rd_p <= reg_rd_i;
    if (reset_n_i) begin
      check("start before sync", 18'(!sync_n_i && lane0_k_o && lane0_data_o == 8'h1C), 18'h0);
    end
    if (!larm) lrun = 1'b0;
    if (larm && !lrun && lane0_k_o && lane0_data_o == `SLIT_K_R) lrun = 1'b1;
    if (lrun && lq.size() > 0) begin
      if (!lq[0][18]) begin
        check("lane octets", {lane1_k_o, lane1_data_o, lane0_k_o, lane0_data_o}, lq[0][17:0]);
      end
      void'(lq.pop_front());
    end
  end

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    {reset_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, subclass_i} = '0;
    {smp_valid_i, smp_a_i, smp_b_i, larm, tl} = '0;
    rng = 32'd21459;
    {smp_ctrl_a_i, smp_ctrl_b_i} = 4'(rng);
    for (int i = 0; i < 24; i++) begin
      rng = xs(rng);
      sa[i] = i < 8 ? rng[13:0] : 14'h0000;
      sb[i] = i < 8 ? rng[29:16] : 14'h0000;
    end
    rng = xs(rng);
    {did, bid, lid0, lid1} = rng[21:0];
    cgs_len = 8'h04 + {4'h0, rng[25:22]};
    rv = '{16'h5E22, 16'h5F01, 16'h1400, 16'h701F, 16'h6E81, 16'h6F01, 16'h7101, 16'h720D,
           16'h730F, 16'h7400, 16'h7500, 16'h8000};
    qt = '{32'h00010000, 32'h01000080, 32'h00030100, 32'h01010100};
    repeat (2) @(posedge clk_sys_i);
    #1;
    reset_n_i = 1'b1;
    wr(`SLIT_A_LCTL, 8'h01);
    foreach (rv[i]) rd(rv[i][15:8], rv[i][7:0]);
    wr(`SLIT_A_FPF, 8'hFF);
    wr(`SLIT_A_DID, did);
    wr(`SLIT_A_BID, {rng[31:28], bid});
    wr(`SLIT_A_LID0, {3'h7, lid0});
    wr(`SLIT_A_LID1, {3'h5, lid1});
    wr(`SLIT_A_KPM, 8'h0B);
    wr(`SLIT_A_SCRL, 8'h00);
    foreach (qt[i]) begin
      wr(`SLIT_A_QCFG, i[1] ? (i[0] ? 8'h22 : 8'h21) : (i[0] ? 8'h12 : 8'h11));
      rd(`SLIT_A_SCRL, qt[i][31:24]);
      rd(`SLIT_A_FPF, qt[i][23:16]);
      rd(`SLIT_A_MCNT, qt[i][15:8]);
      rd(`SLIT_A_HDCF, qt[i][7:0]);
    end
    rd(`SLIT_A_DID, did);
    rd(`SLIT_A_BID, {4'h0, bid});
    rd(`SLIT_A_LID0, {3'h0, lid0});
    rd(`SLIT_A_LID1, {3'h0, lid1});
    rd(`SLIT_A_KPM, 8'h0B);
    rd(`SLIT_A_CKS0, cfg_oct(13, lid0));
    rd(`SLIT_A_CKS1, cfg_oct(13, lid1));
    run_link();
    // second pass: hold, subclass 1 start on the multiframe wrap, fixed tail bits
    wr(`SLIT_A_LCTL, 8'h01);
    subclass_i = 1'b1;
    tl = 2'b11;
    wr(`SLIT_A_TAIL, 8'hE0);
    rd(`SLIT_A_TAIL, 8'hE0);
    rd(`SLIT_A_CKS0, cfg_oct(13, lid0));
    rd(`SLIT_A_CKS1, cfg_oct(13, lid1));
    run_link();
    end_of_test();
  end
endmodule
